// File: pkg/dta_pkg.sv
/*
 * dta_pkg: constants, register map and carrier types of the dual threshold alarm unit.
 * Assumes a 250 MHz core clock and signed 16-bit display values.
 */
`default_nettype none
package dta_pkg;
    // clock and timing
    localparam int          CLK_HZ          = 250000000;        // core clock rate
    localparam int          TICK_PERIOD_S   = 1;                // delay timer step, seconds
    localparam int          TICK_CYCLES     = CLK_HZ * TICK_PERIOD_S;
    localparam logic [15:0] DELAY_MAX_S     = 16'h176f;         // 5999 seconds
    localparam logic [15:0] TOUT_MIN        = 16'h0009;         // timeout active above this
    // value limits and substitutes
    localparam logic signed [15:0] VAL_MAX  = 16'sh270f;        // 9999
    localparam logic signed [15:0] VAL_MIN  = -16'sh07cf;       // -1999
    localparam logic signed [15:0] SUB_OVF  = 16'sh2710;        // 10000
    localparam logic signed [15:0] SUB_UNF  = -16'sh07d0;       // -2000
    // register offsets
    localparam logic [7:0] REG_C1_CFG   = 8'h00;
    localparam logic [7:0] REG_C1_THR   = 8'h01;
    localparam logic [7:0] REG_C1_HYS   = 8'h02;
    localparam logic [7:0] REG_C1_HI    = 8'h03;
    localparam logic [7:0] REG_C1_LO    = 8'h04;
    localparam logic [7:0] REG_C1_OFFD  = 8'h05;
    localparam logic [7:0] REG_C1_OND   = 8'h06;
    localparam logic [7:0] REG_C2_BASE  = 8'h08;                // channel 2 repeats at +8
    localparam logic [7:0] REG_ALARM    = 8'h10;                // alarm status word
    localparam logic [7:0] REG_TOUT     = 8'h11;                // bus timeout setting
    localparam logic [7:0] REG_STATUS   = 8'h12;                // error and flash status
    // config field positions
    localparam int CFG_FUNC_LSB = 0;                            // 3-bit function
    localparam int CFG_ERR_LSB  = 4;                            // 2-bit error reaction
    localparam int CFG_FLASH    = 8;                            // flash enable
    // reset values
    localparam logic signed [15:0] RST_C1_THR = 16'sd100;
    localparam logic signed [15:0] RST_C1_HI  = 16'sd200;
    localparam logic signed [15:0] RST_C2_THR = 16'sd300;
    localparam logic signed [15:0] RST_C2_HI  = 16'sd400;
    localparam logic signed [15:0] RST_C2_LO  = 16'sd300;
    localparam logic signed [15:0] RST_ZERO   = 16'sd0;
    localparam logic [15:0]        RST_TOUT   = 16'h0064;       // 100
    // channel functions
    typedef enum logic [2:0] {
        FN_OFF, FN_EXCEED, FN_UNDERCUT, FN_INSIDE, FN_OUTSIDE, FN_DIGIN, FN_BUS
    } dta_func_t;
    // error reactions
    typedef enum logic [1:0] { ER_NONE, ER_ON, ER_OFF } dta_err_t;
    // per-channel parameter set
    typedef struct packed {
        dta_func_t          func;
        dta_err_t           err;
        logic               flash;
        logic signed [15:0] thr;
        logic signed [15:0] hys;
        logic signed [15:0] hi;
        logic signed [15:0] lo;
        logic [15:0]        off_d;
        logic [15:0]        on_d;
    } dta_chan_cfg_t;
    // measured value with its error flags
    typedef struct packed {
        logic signed [15:0] value;
        logic               ovf;
        logic               unf;
        logic               cks_err;
    } dta_meas_t;
endpackage
`default_nettype wire

// File: verilog/dta_chan.sv
/*
 * dta_chan: one switching-point channel with comparison, error reaction and delays.
 * Assumes a one-cycle second tick and synchronous inputs from the parent.
 */
`default_nettype none
module dta_chan (
    input  wire logic                   core_clk,   // core clock
    input  wire logic                   nrst,       // async reset, low
    input  wire logic                   tick,       // one-second pulse
    input  wire dta_pkg::dta_chan_cfg_t cfg,        // parameter set
    input  wire dta_pkg::dta_meas_t     meas,       // measured value
    input  wire logic                   err_ext,    // extra error, e.g. bus timeout
    input  wire logic                   din,        // digital input level
    input  wire logic                   bus_state,  // master-written state
    output logic                        alarm       // delayed channel output
);
    logic               raw;            // undelayed decision
    logic               cmp_ff;         // hysteresis memory
    logic               first_ff;       // first evaluation after reset
    logic               alarm_ff;       // delayed output state
    logic [15:0]        cnt_ff;         // elapsed seconds of pending change
    logic signed [16:0] v;              // effective value
    logic               err;            // any error condition

    assign err   = meas.cks_err | meas.ovf | meas.unf | err_ext;
    assign alarm = alarm_ff;

    // substituted value when error reaction is none
    always_comb begin
        v = {meas.value[15], meas.value};
        if (meas.ovf) begin
            v = {dta_pkg::SUB_OVF[15], dta_pkg::SUB_OVF};           // see RULE11
        end else if (meas.unf) begin
            v = {dta_pkg::SUB_UNF[15], dta_pkg::SUB_UNF};           // see RULE11
        end
    end

    // hysteresis state of single-threshold functions
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cmp_ff <= 1'b0;
        end else if (cfg.func == dta_pkg::FN_EXCEED) begin
            if (v > cfg.thr) begin
                cmp_ff <= 1'b1;                                      // see RULE3
            end else if (v < cfg.thr - cfg.hys) begin
                cmp_ff <= 1'b0;                                      // see RULE13, see RULE21
            end
        end else if (cfg.func == dta_pkg::FN_UNDERCUT) begin
            if (v < cfg.thr) begin
                cmp_ff <= 1'b1;                                      // see RULE4
            end else if (v > cfg.thr + cfg.hys) begin
                cmp_ff <= 1'b0;                                      // see RULE13, see RULE21
            end
        end else begin
            cmp_ff <= 1'b0;                                          // see RULE12
        end
    end

    // undelayed decision per function, errors override
    always_comb begin
        unique case (cfg.func)
            dta_pkg::FN_OFF:      raw = 1'b0;                        // see RULE2
            dta_pkg::FN_EXCEED,
            dta_pkg::FN_UNDERCUT: raw = cmp_ff;
            dta_pkg::FN_INSIDE:   raw = (v >= cfg.lo) && (v <= cfg.hi);   // see RULE5, see RULE14
            dta_pkg::FN_OUTSIDE:  raw = (v < cfg.lo) || (v > cfg.hi);     // see RULE6, see RULE14
            dta_pkg::FN_DIGIN:    raw = din;                         // see RULE7
            dta_pkg::FN_BUS:      raw = bus_state;                   // see RULE8
            default:              raw = 1'b0;
        endcase
        if (err && cfg.func != dta_pkg::FN_OFF) begin
            if (cfg.err == dta_pkg::ER_ON) begin
                raw = 1'b1;                                          // see RULE9
            end else if (cfg.err == dta_pkg::ER_OFF) begin
                raw = 1'b0;                                          // see RULE10
            end
        end
    end

    // on and off delays; first evaluation after reset skips them
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            alarm_ff <= 1'b0;
            cnt_ff   <= 16'h0000;
            first_ff <= 1'b1;
        end else if (first_ff) begin
            alarm_ff <= raw;                                         // see RULE17
            cnt_ff   <= 16'h0000;
            first_ff <= 1'b0;
        end else if (raw == alarm_ff) begin
            cnt_ff <= 16'h0000;                                      // see RULE22
        end else if (raw && cnt_ff >= cfg.on_d) begin
            alarm_ff <= 1'b1;                                        // see RULE16
            cnt_ff   <= 16'h0000;
        end else if (!raw && cnt_ff >= cfg.off_d) begin
            alarm_ff <= 1'b0;                                        // see RULE15
            cnt_ff   <= 16'h0000;
        end else if (tick) begin
            cnt_ff <= cnt_ff + 16'h0001;                             // see RULE22
        end
    end
endmodule
`default_nettype wire

// File: verilog/dta_top.sv
/*
 * dta_top: dual threshold alarm unit with register port, tick and bus timeout.
 * Assumes synchronous inputs and a simple strobe register port.
 */
// Summary of operation
// RULE1: two independent channels, own function and parameters
// RULE2: function off never asserts output
// RULE3: exceed activates above threshold
// RULE4: undercut activates below threshold
// RULE5: inside window active between limits
// RULE6: outside window active beyond limits
// RULE7: digital input function follows input level
// RULE8: bus function state written by master
// RULE9: error reaction on forces output active
// RULE10: error reaction off forces output inactive
// RULE11: reaction none substitutes 10000 or -2000
// RULE12: threshold up to 9999, ignored in windows
// RULE13: hysteresis only for single-threshold functions
// RULE14: window limits from -1999 to 9999
// RULE15: off-delay 0 to 5999 seconds
// RULE16: on-delay 0 to 5999 seconds
// RULE17: no delay on first evaluation after start
// RULE18: flashing while flagged channel alarm active
// RULE19: bus timeout countdown sets error bit
// RULE20: alarm word low bits, bus-only writes
// RULE21: release past threshold plus or minus hysteresis
// RULE22: delays count seconds, restart on revert
`default_nettype none
module dta_top #(
    parameter int TICK_CYCLES = dta_pkg::TICK_CYCLES    // cycles per second tick
) (
    input  wire logic               core_clk,   // core clock
    input  wire logic               nrst,       // async reset, low
    input  wire logic [7:0]         addr,       // register index
    input  wire logic [15:0]        wdata,      // write data
    input  wire logic               wr,         // write strobe
    input  wire logic               rd,         // read strobe
    output logic [15:0]             rdata,      // read data, cycle after rd
    input  wire dta_pkg::dta_meas_t meas,       // measured value from front end
    input  wire logic               din,        // digital input
    input  wire logic               bus_comm,   // one pulse per bus communication
    output logic [1:0]              relay,      // relay outputs
    output logic                    flash       // display flashing request
);
    dta_pkg::dta_chan_cfg_t cfg_ff [2];         // parameter sets of both channels
    logic [1:0]             bus_ff;             // master-written states
    logic [15:0]            tout_set_ff;        // timeout setting
    logic [15:0]            tout_cnt_ff;        // timeout countdown
    logic                   tout_err_ff;        // timeout error bit
    logic [31:0]            tick_cnt_ff;        // second divider
    logic                   tick_ff;            // second pulse
    logic [15:0]            rdata_ff;           // read data register
    logic [1:0]             relay_ff;           // relay output register
    logic                   flash_ff;           // flash output register
    logic [1:0]             alarm;              // channel outputs
    logic [1:0]             ch_sel;             // channel addressed by read or write
    logic [2:0]             sub;                // field within channel

    assign relay = relay_ff;
    assign flash = flash_ff;
    assign rdata = rdata_ff;
    assign sub   = addr[2:0];

    // clamp a signed value to the settable range
    function automatic logic signed [15:0] clamp(input logic signed [15:0] x,
                                                 input logic signed [15:0] lo);
        if (x > dta_pkg::VAL_MAX) begin
            clamp = dta_pkg::VAL_MAX;
        end else if (x < lo) begin
            clamp = lo;
        end else begin
            clamp = x;
        end
    endfunction

    // clamp a delay to the documented span
    function automatic logic [15:0] dclamp(input logic [15:0] x);
        dclamp = (x > dta_pkg::DELAY_MAX_S) ? dta_pkg::DELAY_MAX_S : x;
    endfunction

    // decode channel of a parameter address
    always_comb begin
        ch_sel = 2'b00;
        if (addr[7:3] == dta_pkg::REG_C1_CFG[7:3]) begin
            ch_sel = 2'b01;
        end else if (addr[7:3] == dta_pkg::REG_C2_BASE[7:3]) begin
            ch_sel = 2'b10;
        end
    end

    // second tick; hardware divider rather than a software timer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff     <= 1'b0;
        end else if (tick_cnt_ff >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff     <= 1'b1;                                     // see RULE22
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
            tick_ff     <= 1'b0;
        end
    end

    // parameter writes, per channel; values clamped to legal span
    for (genvar c = 0; c < 2; c++) begin : g_cfg
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                cfg_ff[c].func  <= dta_pkg::FN_OFF;                  // see RULE2
                cfg_ff[c].err   <= dta_pkg::ER_OFF;
                cfg_ff[c].flash <= 1'b0;
                cfg_ff[c].thr   <= (c == 0) ? dta_pkg::RST_C1_THR : dta_pkg::RST_C2_THR;
                cfg_ff[c].hys   <= dta_pkg::RST_ZERO;
                cfg_ff[c].hi    <= (c == 0) ? dta_pkg::RST_C1_HI : dta_pkg::RST_C2_HI;
                cfg_ff[c].lo    <= (c == 0) ? dta_pkg::RST_ZERO : dta_pkg::RST_C2_LO;
                cfg_ff[c].off_d <= 16'h0000;
                cfg_ff[c].on_d  <= 16'h0000;
            end else if (wr && ch_sel[c]) begin                      // see RULE1
                unique case (sub)
                    dta_pkg::REG_C1_CFG[2:0]: begin
                        if (wdata[dta_pkg::CFG_FUNC_LSB +: 3] <= 3'(dta_pkg::FN_BUS)) begin
                            cfg_ff[c].func <= dta_pkg::dta_func_t'(
                                wdata[dta_pkg::CFG_FUNC_LSB +: 3]);
                        end
                        if (wdata[dta_pkg::CFG_ERR_LSB +: 2] != 2'b11) begin
                            cfg_ff[c].err <= dta_pkg::dta_err_t'(
                                wdata[dta_pkg::CFG_ERR_LSB +: 2]);
                        end
                        cfg_ff[c].flash <= wdata[dta_pkg::CFG_FLASH];
                    end
                    dta_pkg::REG_C1_THR[2:0]:                        // see RULE12
                        cfg_ff[c].thr <= clamp(wdata, dta_pkg::VAL_MIN);
                    dta_pkg::REG_C1_HYS[2:0]: cfg_ff[c].hys <= clamp(wdata, dta_pkg::RST_ZERO);
                    dta_pkg::REG_C1_HI[2:0]:                         // see RULE14
                        cfg_ff[c].hi <= clamp(wdata, dta_pkg::VAL_MIN);
                    dta_pkg::REG_C1_LO[2:0]:                         // see RULE14
                        cfg_ff[c].lo <= clamp(wdata, dta_pkg::VAL_MIN);
                    dta_pkg::REG_C1_OFFD[2:0]: cfg_ff[c].off_d <= dclamp(wdata);   // see RULE15
                    dta_pkg::REG_C1_OND[2:0]:  cfg_ff[c].on_d  <= dclamp(wdata);   // see RULE16
                    default: ;                                       // unused slot
                endcase
            end
        end

        // channel engine
        dta_chan u_chan (
            .core_clk  (core_clk),
            .nrst      (nrst),
            .tick      (tick_ff),
            .cfg       (cfg_ff[c]),
            .meas      (meas),
            .err_ext   (tout_err_ff),                                // see RULE19
            .din       (din),
            .bus_state (bus_ff[c]),
            .alarm     (alarm[c])
        );
    end

    // master-written alarm states, only for bus-controlled channels
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bus_ff <= 2'b00;
        end else if (wr && addr == dta_pkg::REG_ALARM) begin
            for (int c = 0; c < 2; c++) begin
                if (cfg_ff[c].func == dta_pkg::FN_BUS) begin
                    bus_ff[c] <= wdata[c];                           // see RULE20, see RULE8
                end
            end
        end
    end

    // timeout setting
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tout_set_ff <= dta_pkg::RST_TOUT;
        end else if (wr && addr == dta_pkg::REG_TOUT) begin
            tout_set_ff <= wdata;
        end
    end

    // timeout countdown in seconds; a communication wins over expiry
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tout_cnt_ff <= dta_pkg::RST_TOUT;
            tout_err_ff <= 1'b0;
        end else if (tout_set_ff <= dta_pkg::TOUT_MIN) begin
            tout_cnt_ff <= tout_set_ff;                              // monitor disabled
            tout_err_ff <= 1'b0;
        end else if (bus_comm) begin
            tout_cnt_ff <= tout_set_ff;                              // see RULE19
            tout_err_ff <= 1'b0;
        end else if (tout_cnt_ff == 16'h0000) begin
            tout_err_ff <= 1'b1;                                     // see RULE19
        end else if (tick_ff) begin
            tout_cnt_ff <= tout_cnt_ff - 16'h0001;
        end
    end

    // outputs registered straight from the channel decisions
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            relay_ff <= 2'b00;
            flash_ff <= 1'b0;
        end else begin
            relay_ff <= alarm;
            flash_ff <= (alarm[0] & cfg_ff[0].flash) | (alarm[1] & cfg_ff[1].flash); // see RULE18
        end
    end

    // read port; unmapped addresses read zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= 16'h0000;
        end else if (rd) begin
            rdata_ff <= 16'h0000;
            if (ch_sel != 2'b00) begin
                unique case (sub)
                    dta_pkg::REG_C1_CFG[2:0]: rdata_ff <= {7'h00, cfg_ff[ch_sel[1]].flash,
                        2'b00, cfg_ff[ch_sel[1]].err, 1'b0, cfg_ff[ch_sel[1]].func};
                    dta_pkg::REG_C1_THR[2:0]:  rdata_ff <= cfg_ff[ch_sel[1]].thr;
                    dta_pkg::REG_C1_HYS[2:0]:  rdata_ff <= cfg_ff[ch_sel[1]].hys;
                    dta_pkg::REG_C1_HI[2:0]:   rdata_ff <= cfg_ff[ch_sel[1]].hi;
                    dta_pkg::REG_C1_LO[2:0]:   rdata_ff <= cfg_ff[ch_sel[1]].lo;
                    dta_pkg::REG_C1_OFFD[2:0]: rdata_ff <= cfg_ff[ch_sel[1]].off_d;
                    dta_pkg::REG_C1_OND[2:0]:  rdata_ff <= cfg_ff[ch_sel[1]].on_d;
                    default:                   rdata_ff <= 16'h0000;
                endcase
            end else if (addr == dta_pkg::REG_ALARM) begin
                rdata_ff <= {14'h0000, alarm};                       // see RULE20
            end else if (addr == dta_pkg::REG_TOUT) begin
                rdata_ff <= tout_set_ff;
            end else if (addr == dta_pkg::REG_STATUS) begin
                rdata_ff <= {14'h0000, flash_ff, tout_err_ff};       // see RULE19
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/dta_fe_model.sv
/* dta_fe_model: measurement front end, value plus error flags.
   The bench calls put right after a rising clock edge. */
`default_nettype none
module dta_fe_model (
    output var dta_pkg::dta_meas_t meas // value and flags
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels only; they change on bench request, never in between
    initial meas = '0;
    task automatic put(input logic [15:0] v, input logic [2:0] f);
        meas <= {v, f};
    endtask
endmodule
`default_nettype wire

// File: tb/dta_top_sva.sv
/* dta_top_sva: port assertions for dta_top.
   Bound to dta_top below; sees only its ports. */
`default_nettype none
module dta_top_sva (
    input wire logic        core_clk, // clock
    input wire logic        nrst,     // reset, low
    input wire logic [7:0]  addr,     // index
    input wire logic [15:0] wdata,    // write data
    input wire logic        wr,       // write strobe
    input wire logic        rd,       // read strobe
    input wire logic [15:0] rdata,    // read data
    input wire logic [1:0]  relay,    // relays
    input wire logic        flash     // flashing
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    gap_read_a: assert property (
        rd && (addr == 8'h07 || addr > 8'h12) |=> rdata == 16'h0)
        else $error("unmapped read not zero");
    alarm_word_a: assert property (
        rd && addr == dta_pkg::REG_ALARM |=> rdata == {14'h0, relay})
        else $error("alarm word differs from relays");
    flash_cause_a: assert property (flash |-> relay != 2'b00)
        else $error("flash without alarm");
    status_word_a: assert property (
        rd && addr == dta_pkg::REG_STATUS |=> rdata[15:2] == 14'h0)
        else $error("status word high bits set");
    thr_clamp_a: assert property (
        wr && addr == 8'h01 && $signed(wdata) > dta_pkg::VAL_MAX ##1
        rd && addr == 8'h01 |=> rdata == dta_pkg::VAL_MAX)
        else $error("threshold not clamped");
    lim_clamp_a: assert property (
        wr && addr == 8'h03 && $signed(wdata) < dta_pkg::VAL_MIN ##1
        rd && addr == 8'h03 |=> rdata == dta_pkg::VAL_MIN)
        else $error("limit not clamped");
    delay_clamp_a: assert property (
        wr && addr == 8'h05 && wdata > dta_pkg::DELAY_MAX_S ##1
        rd && addr == 8'h05 |=> rdata == dta_pkg::DELAY_MAX_S)
        else $error("delay not clamped");
    bad_func_a: assert property (
        wr && addr == 8'h00 && wdata[2:0] == 3'h7 ##1
        rd && addr == 8'h00 |=> rdata[2:0] != 3'h7)
        else $error("illegal function kept");
    cover property ($rose(relay[0]));
    cover property ($rose(flash));
    cover property (rd && addr == dta_pkg::REG_ALARM);
endmodule
bind dta_top dta_top_sva i_sva (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .relay(relay), .flash(flash));
`default_nettype wire

// File: tb/dual_threshold_alarm_unit_test.sv
/* dual_threshold_alarm_unit_test: self-checking bench for dta_top.
   Assumes a 10-cycle second tick and the front end model. */
`default_nettype none
module dual_threshold_alarm_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0; // 250 MHz
    logic        nrst, wr, rd;    // reset and strobes
    logic [7:0]  addr;            // register index
    logic [15:0] wdata, rdata;    // register data
    logic        din, bus_comm;   // digital input, comm pulse
    logic [1:0]  relay;           // relays
    logic        flash;           // flashing
    logic        rd_q = 1'b0;     // read issued last cycle
    int          error_cnt = 0;   // mismatches
    int          n_compared = 0;  // comparisons
    int          seed = 32'h8096; // random seed
    int          v;               // random value
    logic [15:0] exp_q[$];        // pending read results
    dta_pkg::dta_meas_t meas;     // front end value
    // cfg, value, {ovf,unf,cks,din}, expected relay 0
    logic [35:0] st[17] = '{36'h001_0065_0_1, 36'h001_005f_0_1, 36'h001_0059_0_0,
        36'h002_0063_0_1, 36'h002_006d_0_1, 36'h002_006f_0_0, 36'h003_00c8_0_1,
        36'h003_00c9_0_0, 36'h004_00c9_0_1, 36'h004_0064_0_0, 36'h005_0064_1_1,
        36'h005_0064_0_0, 36'h000_270f_1_0, 36'h011_0000_2_1, 36'h021_1000_8_0,
        36'h001_0000_8_1, 36'h002_0200_4_1};
    logic [7:0]  ra[8] = '{8'h00, 8'h01, 8'h03, 8'h09, 8'h0b, 8'h0c, 8'h11, 8'h07};
    logic [15:0] rv[8] = '{16'h0020, 16'h0064, 16'h00c8, 16'h012c, 16'h0190, 16'h012c,
        16'h0064, 16'h0000};
    // clock
    always #2 core_clk = ~core_clk;
    dta_fe_model i_fe (.meas(meas));
    dta_top #(.TICK_CYCLES(10)) i_dut (.core_clk(core_clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .meas(meas), .din(din),
        .bus_comm(bus_comm), .relay(relay), .flash(flash));
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // strobes stay up until cyc drops them, so back-to-back access is legal
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        wr <= 1'b1; rd <= 1'b0; addr <= a; wdata <= d; @(posedge core_clk);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [15:0] e);
        rd <= 1'b1; wr <= 1'b0; addr <= a; exp_q.push_back(e); @(posedge core_clk);
    endtask
    task automatic cyc(input int n);
        wr <= 1'b0; rd <= 1'b0; bus_comm <= 1'b0; repeat (n) @(posedge core_clk);
    endtask
    task automatic rly(input logic [1:0] e);
        cmp("relay", {14'h0, e}, {14'h0, relay});
    endtask
    task automatic conclude;
        if (error_cnt == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // read results land the cycle after the strobe
    always @(posedge core_clk) begin
        if (rd_q) cmp("rdata", exp_q.pop_front(), rdata);
        rd_q <= rd;
    end
    // hang guard, well past the expected run of about 510 cycles
    initial begin
        repeat (3000) @(posedge core_clk);
        error_cnt++;
        conclude();
    end
    initial begin
        {nrst, wr, rd, din, bus_comm, addr, wdata} = '0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        foreach (ra[i]) rreg(ra[i], rv[i]);
        wreg(8'h01, 16'h2ee0); rreg(8'h01, 16'h270f);
        wreg(8'h03, 16'hf448); rreg(8'h03, 16'hf831);
        wreg(8'h05, 16'h1b58); rreg(8'h05, 16'h176f);
        wreg(8'h00, 16'h0007); rreg(8'h00, 16'h0000);
        wreg(8'h01, 16'h0064); wreg(8'h02, 16'h000a); wreg(8'h03, 16'h00c8); wreg(8'h05, 16'h0);
        // function, hysteresis and error reaction table on channel 1
        foreach (st[i]) begin
            wreg(8'h00, {4'h0, st[i][35:24]});
            i_fe.put(st[i][23:8], st[i][7:5]);
            din <= st[i][4];
            cyc(6);
            rly({1'b0, st[i][0]});
        end
        wreg(8'h00, 16'h0003);
        repeat (16) begin
            v = $random(seed) % 400 + 100;
            i_fe.put(v[15:0], 3'h0);
            cyc(5);
            rly({1'b0, v >= 0 && v <= 200});
        end
        // bus-driven channel 2; channel 1 is off so its bit must not stick
        wreg(8'h00, 16'h0000); wreg(8'h08, 16'h0106); wreg(8'h10, 16'h0003);
        cyc(4);
        rly(2'b10);
        rreg(8'h10, 16'h0002);
        rreg(8'h12, 16'h0002);
        cyc(1);
        cmp("flash", 16'h1, {15'h0, flash});
        wreg(8'h10, 16'h0000); wreg(8'h08, 16'h0000);
        cyc(4);
        rly(2'b00);
        // two-second delays both ways
        wreg(8'h05, 16'h0002); wreg(8'h06, 16'h0002); wreg(8'h00, 16'h0001);
        i_fe.put(16'h0096, 3'h0);
        cyc(5); rly(2'b00);
        cyc(30); rly(2'b01);
        i_fe.put(16'h0032, 3'h0);
        cyc(5); rly(2'b01);
        cyc(30); rly(2'b00);
        // bus timeout of ten seconds drives the error reaction
        wreg(8'h11, 16'h000a); wreg(8'h00, 16'h0011);
        bus_comm <= 1'b1; wr <= 1'b0; @(posedge core_clk);
        cyc(150);
        rreg(8'h12, 16'h0001);
        cyc(1); rly(2'b01);
        bus_comm <= 1'b1; @(posedge core_clk);
        cyc(40); rly(2'b00);
        rreg(8'h12, 16'h0000);
        cyc(2);
        conclude();
    end
endmodule
`default_nettype wire
